// [nfc_flash_model.sv]
// behavioural flash device answering the host sequencer
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter logic [15:0] DEV_ID = 16'h5C3A  // arbitrary identity value
) (
  // bus pins
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [22:0] addr,
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out
);
  logic [22:0] a_q;
  logic [22:0] wa[$];
  logic [15:0] wd[$];
  int          ucnt = 0;
  logic        asel = 1'b0;
  wire         strobe = ce_n | we_n;
  initial dq_out = 16'h0;
  // ----------------------------------------
  // write capture and command tracking
  // ----------------------------------------
  always @(negedge strobe) a_q = addr;
  always @(posedge strobe) begin
    wa.push_back(a_q);
    wd.push_back(dq_in);
    if (a_q[11:0] == 12'h555 && dq_in[7:0] == 8'hAA) ucnt = 1;
    else if (ucnt == 1 && a_q[11:0] == 12'h2AA && dq_in[7:0] == 8'h55) ucnt = 2;
    else begin
      if (ucnt == 2 && dq_in[7:0] == 8'h90) asel = 1'b1;
      else if (dq_in[7:0] == 8'hF0 || dq_in[7:0] == 8'h00) asel = 1'b0;
      ucnt = 0;
    end
  end
  // ----------------------------------------
  // read data, changing pattern when idle
  // ----------------------------------------
  always @(ce_n, oe_n, addr) begin
    if (!ce_n && !oe_n) dq_out = asel ? (addr[3:0] == 4'h2 ? {15'h0, addr[22]}
                                        : DEV_ID ^ {12'h0, addr[3:0]}) : addr[15:0] ^ 16'hC3A5;
    else dq_out = ~dq_out;
  end
endmodule

// [nfc_host.sv]
// host sequencer issuing flash command sequences on the parallel bus
`timescale 1ns/1ps
module nfc_host #(
  parameter int AW = 23,
  parameter int DW = 16,
  parameter int WB_PAGE_BITS = 8
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // command port
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire nfc_pkg::nfc_op_t      cmd_op,
  input  wire logic [AW-1:0]         cmd_addr,
  input  wire logic [DW-1:0]         cmd_data,
  input  wire logic [5:0]            cmd_count,
  output logic                       wr_req,
  input  wire logic [DW-1:0]         wr_data,
  output logic                       rd_valid,
  output logic [DW-1:0]              rd_data,
  output logic                       bypass_active,
  // flash pins
  output logic                       flash_ce_n,
  output logic                       flash_we_n,
  output logic                       flash_oe_n,
  output logic [AW-1:0]              flash_addr,
  output logic [DW-1:0]              flash_dq_o,
  output logic                       flash_dq_oe_n,
  input  wire logic [DW-1:0]         flash_dq_i
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_SETUP = 5'b00010,
    S_LOW   = 5'b00100,
    S_HIGH  = 5'b01000,
    S_READ  = 5'b10000
  } nfc_state_t;

  typedef struct packed {
    nfc_state_t       st;
    nfc_pkg::nfc_op_t op;
    logic [5:0]       step;
    logic [5:0]       last;
    logic [5:0]       wcnt;
    logic [3:0]       tmr;
    logic [AW-1:0]    base;
    logic [DW-1:0]    pdat;
    logic [AW-1:0]    a;
    logic [DW-1:0]    d;
    logic             is_rd;
    logic             byp;
    logic             rv;
    logic [DW-1:0]    rdat;
    logic [DW-1:0]    s1;
    logic [DW-1:0]    s2;
  } nfc_reg_t;

  nfc_reg_t q, d;

  // low-bit command address, upper bits zero
  function automatic logic [AW-1:0] cad(input logic [11:0] a);
    cad = {{(AW-12){1'b0}}, a};
  endfunction

  function automatic logic [DW-1:0] cdt(input logic [7:0] v);
    cdt = {{(DW-8){1'b0}}, v};
  endfunction

  // sector address: any address inside the sector
  function automatic logic [AW-1:0] sect(input logic [AW-1:0] a);
    sect = a;
  endfunction

  // number of bus cycles of each operation
  function automatic logic [5:0] seq_len(input nfc_pkg::nfc_op_t op, input logic [5:0] n);
    case (op)
      nfc_pkg::NFC_OP_READ:    seq_len = 6'd1;
      nfc_pkg::NFC_OP_RESUME,
      nfc_pkg::NFC_OP_RESET,
      nfc_pkg::NFC_OP_QUERY:   seq_len = 6'd1;
      nfc_pkg::NFC_OP_PROG:    seq_len = 6'd4;
      nfc_pkg::NFC_OP_BYP_PRG,
      nfc_pkg::NFC_OP_BYP_OUT: seq_len = 6'd2;
      nfc_pkg::NFC_OP_SEC_OUT: seq_len = 6'd4;
      nfc_pkg::NFC_OP_AUTOSEL: seq_len = 6'd6;
      nfc_pkg::NFC_OP_WBUF:    seq_len = 6'(nfc_pkg::WBUF_OVERHEAD) + n;
      default:                 seq_len = 6'd3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // cycle address/data/direction per step
  // ----------------------------------------------------------------
  logic [AW-1:0] ca;
  logic [DW-1:0] cd;
  logic          crd;
  logic          cwr;
  always_comb begin
    ca  = cad(nfc_pkg::ADDR_UNLOCK1);
    cd  = cdt(nfc_pkg::DAT_UNLOCK1);
    crd = 1'b0;
    cwr = 1'b0;
    if (q.step == 6'd1) begin
      ca = cad(nfc_pkg::ADDR_UNLOCK2);
      cd = cdt(nfc_pkg::DAT_UNLOCK2);
    end
    case (q.op)
      nfc_pkg::NFC_OP_READ: begin
        ca  = q.base;
        crd = 1'b1;
      end
      nfc_pkg::NFC_OP_RESUME: begin
        cd = cdt(nfc_pkg::DAT_RESUME);
      end
      nfc_pkg::NFC_OP_RESET: begin
        cd = cdt(nfc_pkg::DAT_RESET);
      end
      nfc_pkg::NFC_OP_QUERY: begin
        ca = cad(nfc_pkg::ADDR_QUERY);
        cd = cdt(nfc_pkg::DAT_QUERY);
      end
      nfc_pkg::NFC_OP_ABORT: if (q.step == 6'd2) cd = cdt(nfc_pkg::DAT_RESET);
      nfc_pkg::NFC_OP_SEC_IN: if (q.step == 6'd2) cd = cdt(nfc_pkg::DAT_SECURE);
      nfc_pkg::NFC_OP_ECC_IN: if (q.step == 6'd2) cd = cdt(nfc_pkg::DAT_OVERLAY);
      nfc_pkg::NFC_OP_BYP_IN: if (q.step == 6'd2) cd = cdt(nfc_pkg::DAT_BYPASS);
      nfc_pkg::NFC_OP_SEC_OUT: begin
        if (q.step == 6'd2) cd = cdt(nfc_pkg::DAT_AUTOSEL);
        if (q.step == 6'd3) begin
          ca = cad(12'h000);
          cd = cdt(nfc_pkg::DAT_ZERO);
        end
      end
      nfc_pkg::NFC_OP_AUTOSEL: begin
        if (q.step == 6'd2) cd = cdt(nfc_pkg::DAT_AUTOSEL);
        if (q.step >= 6'd3) begin
          // three separate id reads: offsets 01, 0E, 0F, or 02 in sector
          crd = 1'b1;
          ca  = q.base;
          if (q.step == 6'd4) ca = (q.base & ~cad(12'h00F)) | cad(12'h00E);
          if (q.step == 6'd5) ca = q.base | cad(12'h00F);
        end
      end
      nfc_pkg::NFC_OP_PROG: begin
        if (q.step == 6'd2) cd = cdt(nfc_pkg::DAT_PROG);
        if (q.step == 6'd3) begin
          ca = q.base;
          cd = q.pdat;
        end
      end
      nfc_pkg::NFC_OP_BYP_PRG: begin
        cd = cdt(nfc_pkg::DAT_PROG);
        if (q.step == 6'd1) begin
          ca = q.base;
          cd = q.pdat;
        end
      end
      nfc_pkg::NFC_OP_BYP_OUT: begin
        cd = cdt(nfc_pkg::DAT_AUTOSEL);
        if (q.step == 6'd1) cd = cdt(nfc_pkg::DAT_ZERO);
      end
      nfc_pkg::NFC_OP_WBUF: begin
        if (q.step == 6'd2) begin
          ca = sect(q.base);
          cd = cdt(nfc_pkg::DAT_WBUF);
        end else if (q.step == 6'd3) begin
          ca = sect(q.base);
          cd = {{(DW-6){1'b0}}, q.wcnt};
        end else if (q.step == q.last) begin
          ca = sect(q.base);
          cd = cdt(nfc_pkg::DAT_CONFIRM);
        end else if (q.step >= 6'd4) begin
          // page-relative walk inside one buffer page
          ca = {q.base[AW-1:WB_PAGE_BITS],
                q.base[WB_PAGE_BITS-1:0] + WB_PAGE_BITS'(q.step - 6'd4)};
          cd  = wr_data;
          cwr = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d    = q;
    d.rv = 1'b0;
    d.s1 = flash_dq_i;
    d.s2 = q.s1;
    case (q.st)
      S_IDLE: begin
        if (cmd_valid) begin
          d.op   = cmd_op;
          d.base = cmd_addr;
          d.pdat = cmd_data;
          d.wcnt = cmd_count;
          d.last = seq_len(cmd_op, cmd_count + 6'd1) - 6'd1;
          d.step = 6'd0;
          d.st   = S_SETUP;
          if (cmd_op == nfc_pkg::NFC_OP_BYP_IN) d.byp = 1'b1;
          if (cmd_op == nfc_pkg::NFC_OP_BYP_OUT) d.byp = 1'b0;
        end
      end
      S_SETUP: begin
        // address and data settle one cycle before the strobes fall
        if (q.tmr == 4'd0) begin
          d.a     = ca;
          d.d     = cd;
          d.is_rd = crd;
          d.tmr   = 4'd1;
        end else begin
          d.tmr = crd ? 4'(nfc_pkg::READ_CY) : 4'(nfc_pkg::STROBE_LOW_CY);
          d.st  = S_LOW;
        end
      end
      S_LOW: begin
        d.tmr = q.tmr - 4'd1;
        if (q.tmr == 4'd1) begin
          d.tmr = 4'(nfc_pkg::STROBE_HI_CY);
          d.st  = S_HIGH;
          if (q.is_rd) begin
            d.rv   = 1'b1;
            d.rdat = q.s2;
          end
        end
      end
      S_HIGH: begin
        // data held through rising edge and recovery
        d.tmr = q.tmr - 4'd1;
        if (q.tmr == 4'd1) begin
          if (q.step == q.last) begin
            d.st = S_IDLE;
          end else begin
            d.step = q.step + 6'd1;
            d.st   = S_SETUP;
          end
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q      <= '0;
      q.st   <= S_IDLE;
      q.op   <= nfc_pkg::NFC_OP_READ;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_ready     = (q.st == S_IDLE);
  assign wr_req        = (q.st == S_SETUP) && (q.tmr == 4'd0) && cwr;
  assign rd_valid      = q.rv;
  assign rd_data       = q.rdat;
  assign bypass_active = q.byp;
  assign flash_ce_n    = !(q.st == S_LOW || q.st == S_HIGH);
  assign flash_we_n    = !(q.st == S_LOW && !q.is_rd);
  assign flash_oe_n    = !(q.st == S_LOW && q.is_rd);
  assign flash_addr    = q.a;
  assign flash_dq_o    = q.d;
  assign flash_dq_oe_n = q.is_rd || q.st == S_IDLE;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_we_pulse;
    !flash_we_n ##1 flash_we_n;
  endsequence

  property p_addr_stable;
    @(posedge clk) disable iff (!arst_n)
      !flash_we_n |-> $stable(flash_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved in strobe");

  property p_data_hold;
    @(posedge clk) disable iff (!arst_n)
      s_we_pulse |-> $stable(flash_dq_o) && !flash_ce_n;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data changed at rising edge");

  property p_confirm;
    @(posedge clk) disable iff (!arst_n)
      (!flash_we_n && q.op == nfc_pkg::NFC_OP_WBUF && q.step == q.last)
        |-> flash_dq_o[7:0] == nfc_pkg::DAT_CONFIRM;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm data wrong");

  property p_resume;
    @(posedge clk) disable iff (!arst_n)
      (!flash_we_n && q.op == nfc_pkg::NFC_OP_RESUME) |-> flash_dq_o[7:0] == nfc_pkg::DAT_RESUME;
  endproperty
  a_resume: assert property (p_resume) else $error("resume data wrong");

  property p_len;
    @(posedge clk) disable iff (!arst_n)
      q.op == nfc_pkg::NFC_OP_WBUF && q.st != S_IDLE |-> q.last < 6'(nfc_pkg::MAX_SEQ_CYCLES);
  endproperty
  a_len: assert property (p_len) else $error("buffer sequence too long");

  property p_unlock2;
    @(posedge clk) disable iff (!arst_n)
      (!flash_we_n && q.step == 6'd1 && q.op != nfc_pkg::NFC_OP_WBUF
       && q.op != nfc_pkg::NFC_OP_BYP_PRG
       && q.op != nfc_pkg::NFC_OP_BYP_OUT && q.op != nfc_pkg::NFC_OP_READ)
        |-> flash_addr[11:0] == nfc_pkg::ADDR_UNLOCK2;
  endproperty
  a_unlock2: assert property (p_unlock2) else $error("second unlock address wrong");

  property p_page;
    @(posedge clk) disable iff (!arst_n)
      (q.op == nfc_pkg::NFC_OP_WBUF && !flash_we_n && q.step >= 6'd4 && q.step != q.last)
        |-> flash_addr[AW-1:WB_PAGE_BITS] == q.base[AW-1:WB_PAGE_BITS];
  endproperty
  a_page: assert property (p_page) else $error("buffer word outside page");

  property p_read_no_we;
    @(posedge clk) disable iff (!arst_n)
      !flash_oe_n |-> flash_we_n && flash_dq_oe_n;
  endproperty
  a_read_no_we: assert property (p_read_no_we) else $error("read overlapped write");
endmodule

// [nfc_host_test.sv]
// self-checking bench for the flash command sequencer host
`timescale 1ns/1ps
module nfc_host_test;
  localparam logic [15:0] DEV_ID = 16'h5C3A;  // arbitrary identity value
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  nfc_pkg::nfc_op_t cmd_op = nfc_pkg::NFC_OP_READ;
  logic [22:0] cmd_addr = 23'h0;
  logic [15:0] cmd_data = 16'h0;
  logic [5:0]  cmd_count = 6'h0;
  logic [15:0] wr_data = 16'h0;
  logic        cmd_ready, wr_req, rd_valid, byp, ce_n, we_n, oe_n, dq_oe_n;
  logic [15:0] rd_data, dq_o, dq_m, bus;
  logic [22:0] fa, r;
  int          errors = 0, num_checks = 0, seed = 32'hB177, widx = 0;
  logic [15:0] wq[$], rq[$];
  logic [22:0] ea[$];
  logic [15:0] ed[$];
  int          ek[$];
  nfc_pkg::nfc_op_t ops[8] = '{nfc_pkg::NFC_OP_RESUME, nfc_pkg::NFC_OP_ABORT,
    nfc_pkg::NFC_OP_SEC_IN, nfc_pkg::NFC_OP_SEC_OUT, nfc_pkg::NFC_OP_ECC_IN,
    nfc_pkg::NFC_OP_RESET, nfc_pkg::NFC_OP_QUERY, nfc_pkg::NFC_OP_RESET};
  assign bus = dq_oe_n ? dq_m : dq_o;
  always #10 clk = ~clk;
  always @(negedge clk) wr_data = (widx < wq.size()) ? wq[widx] : 16'h0;
  always @(posedge clk) if (wr_req === 1'b1) widx++;
  always @(negedge clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
  nfc_host nfc_host_i (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_count(cmd_count), .wr_req(wr_req), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .bypass_active(byp), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n),
    .flash_dq_i(bus));
  nfc_flash_model #(.DEV_ID(DEV_ID)) nfc_flash_model_i (.ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .addr(fa), .dq_in(bus), .dq_out(dq_m));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk_val(string what, logic [22:0] exp, logic [22:0] got);
    num_checks++;
    if (exp !== got) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ex(int k, logic [22:0] a, logic [15:0] d);
    ek.push_back(k);
    ea.push_back(a);
    ed.push_back(d);
  endtask
  task automatic unl();
    ex(0, 23'h555, 16'h00AA);
    ex(0, 23'h2AA, 16'h0055);
  endtask
  // kinds: 0 low address and byte, 1 full, 2 byte only, 3 full address and byte
  task automatic chk_bus();
    logic [22:0] a, xa;
    logic [15:0] d, xd;
    int k;
    chk_val("cycles", 23'(ea.size()), 23'(nfc_flash_model_i.wa.size()));
    while (ea.size() > 0 && nfc_flash_model_i.wa.size() > 0) begin
      a = nfc_flash_model_i.wa.pop_front();
      d = nfc_flash_model_i.wd.pop_front();
      xa = ea.pop_front();
      xd = ed.pop_front();
      k = ek.pop_front();
      num_checks++;
      if (!((k == 2 || (k == 0 ? a[11:0] === xa[11:0] : a === xa))
          && (k == 1 ? d === xd : d[7:0] === xd[7:0]))) begin
        errors++;
        $display("Error write expected %h %h seen %h %h", xa, xd, a, d);
      end
    end
    ea.delete();
    ed.delete();
    ek.delete();
    nfc_flash_model_i.wa.delete();
    nfc_flash_model_i.wd.delete();
  endtask
  task automatic chk_rd(logic [15:0] exp);
    chk_val("read", 23'(exp), (rq.size() > 0) ? 23'(rq.pop_front()) : 23'h7FFFFF);
  endtask
  task automatic run(nfc_pkg::nfc_op_t op, logic [22:0] a, logic [15:0] d, logic [5:0] n);
    int t;
    t = 0;
    @(negedge clk);
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_count = n;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && t < 50) begin @(negedge clk); t++; end
    @(negedge clk);
    cmd_valid = 1'b0;
    t = 0;
    while (cmd_ready !== 1'b1 && t < 3000) begin @(negedge clk); t++; end
    if (t >= 3000) chk_val("ready", 23'h1, 23'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #600000;
    chk_val("watchdog", 23'h1, 23'h0);
    finish_test();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    nfc_flash_model_i.wa.delete();
    nfc_flash_model_i.wd.delete();
    for (int i = 0; i < 3; i++) begin
      r = 23'($random(seed));
      run(nfc_pkg::NFC_OP_READ, r, 16'h0, 6'h0);
      chk_rd(r[15:0] ^ 16'hC3A5);
      chk_bus();
    end
    $display("test reads done");
    r = 23'($random(seed));
    unl();
    ex(0, 23'h555, 16'h00A0);
    ex(1, r, r[15:0] ^ 16'h1234);
    run(nfc_pkg::NFC_OP_PROG, r, r[15:0] ^ 16'h1234, 6'h0);
    chk_bus();
    $display("test program done");
    for (int j = 0; j < 2; j++) begin
      logic [5:0] n;
      n = j ? 6'd31 : 6'd0;
      r = 23'($random(seed)) & 23'h7FFF0F;
      wq.delete();
      for (int i = 0; i <= n; i++) wq.push_back(16'($random(seed)));
      widx = 0;
      unl();
      ex(3, r, 16'h0025);
      ex(1, r, {10'h0, n});
      for (int i = 0; i <= n; i++) ex(1, {r[22:8], 8'(r[7:0] + i)}, wq[i]);
      ex(3, r, 16'h0029);
      if (n == 31) chk_val("length", 23'd37, 23'(ea.size()));
      run(nfc_pkg::NFC_OP_WBUF, r, 16'h0, n);
      chk_bus();
    end
    $display("test buffer done");
    foreach (ops[i]) begin
      case (ops[i])
        nfc_pkg::NFC_OP_RESUME: ex(2, 23'h0, 16'h0050);
        nfc_pkg::NFC_OP_RESET:  ex(2, 23'h0, 16'h00F0);
        nfc_pkg::NFC_OP_QUERY:  ex(0, 23'h055, 16'h0098);
        default: begin
          unl();
          ex(0, 23'h555, ops[i] == nfc_pkg::NFC_OP_ABORT ? 16'h00F0
            : ops[i] == nfc_pkg::NFC_OP_SEC_IN ? 16'h0088
            : ops[i] == nfc_pkg::NFC_OP_ECC_IN ? 16'h0075 : 16'h0090);
          if (ops[i] == nfc_pkg::NFC_OP_SEC_OUT) ex(2, 23'h0, 16'h0000);
        end
      endcase
      run(ops[i], 23'($random(seed)), 16'h0, 6'h0);
      chk_bus();
    end
    $display("test commands done");
    r = 23'($random(seed));
    unl();
    ex(0, 23'h555, 16'h0020);
    run(nfc_pkg::NFC_OP_BYP_IN, 23'h0, 16'h0, 6'h0);
    chk_val("bypass", 23'h1, 23'(byp));
    ex(2, 23'h0, 16'h00A0);
    ex(1, r, 16'hBEEF);
    run(nfc_pkg::NFC_OP_BYP_PRG, r, 16'hBEEF, 6'h0);
    chk_val("bypass", 23'h1, 23'(byp));
    ex(2, 23'h0, 16'h0090);
    ex(2, 23'h0, 16'h0000);
    run(nfc_pkg::NFC_OP_BYP_OUT, 23'h0, 16'h0, 6'h0);
    chk_val("bypass", 23'h0, 23'(byp));
    chk_bus();
    $display("test bypass done");
    for (int j = 0; j < 3; j++) begin
      r = (j == 0) ? 23'h000001 : (j == 1) ? 23'h400002 : 23'h000002;
      unl();
      ex(0, 23'h555, 16'h0090);
      ex(2, 23'h0, 16'h00F0);
      run(nfc_pkg::NFC_OP_AUTOSEL, r, 16'h0, 6'h0);
      chk_rd(r[3:0] == 4'h2 ? {15'h0, r[22]} : DEV_ID ^ 16'h0001);
      chk_rd(DEV_ID ^ 16'h000E);
      chk_rd(DEV_ID ^ 16'h000F);
      run(nfc_pkg::NFC_OP_RESET, 23'h0, 16'h0, 6'h0);
      run(nfc_pkg::NFC_OP_READ, r, 16'h0, 6'h0);
      chk_rd(r[15:0] ^ 16'hC3A5);
      chk_bus();
    end
    $display("test autoselect done");
    finish_test();
  end
endmodule

// [nfc_pkg.sv]
// constants for the flash command sequencer host
package nfc_pkg;
  // unlock and command addresses (low bits only matter)
  localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h2AA;
  localparam logic [11:0] ADDR_QUERY   = 12'h055;
  // command data bytes
  localparam logic [7:0] DAT_UNLOCK1   = 8'hAA;
  localparam logic [7:0] DAT_UNLOCK2   = 8'h55;
  localparam logic [7:0] DAT_RESET     = 8'hF0;
  localparam logic [7:0] DAT_RESET_ALT = 8'hFF;
  localparam logic [7:0] DAT_PROG      = 8'hA0;
  localparam logic [7:0] DAT_WBUF      = 8'h25;
  localparam logic [7:0] DAT_CONFIRM   = 8'h29;
  localparam logic [7:0] DAT_RESUME    = 8'h50;
  localparam logic [7:0] DAT_SECURE    = 8'h88;
  localparam logic [7:0] DAT_OVERLAY   = 8'h75;
  localparam logic [7:0] DAT_AUTOSEL   = 8'h90;
  localparam logic [7:0] DAT_BYPASS    = 8'h20;
  localparam logic [7:0] DAT_QUERY     = 8'h98;
  localparam logic [7:0] DAT_ZERO      = 8'h00;
  // write-to-buffer limits
  localparam int MAX_SEQ_CYCLES = 37;
  localparam int WBUF_OVERHEAD  = 5;
  localparam int MAX_WORDS      = MAX_SEQ_CYCLES - WBUF_OVERHEAD;
  // strobe timing in ns and derived clock counts at 50 MHz
  localparam int CLK_NS        = 20;
  localparam int STROBE_LOW_NS = 40;
  localparam int STROBE_HI_NS  = 40;
  localparam int STROBE_LOW_CY = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_HI_CY  = (STROBE_HI_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CY       = 4;
  // host operations
  typedef enum logic [3:0] {
    NFC_OP_READ    = 4'h0,
    NFC_OP_PROG    = 4'h1,
    NFC_OP_WBUF    = 4'h2,
    NFC_OP_RESUME  = 4'h3,
    NFC_OP_RESET   = 4'h4,
    NFC_OP_ABORT   = 4'h5,
    NFC_OP_SEC_IN  = 4'h6,
    NFC_OP_SEC_OUT = 4'h7,
    NFC_OP_ECC_IN  = 4'h8,
    NFC_OP_QUERY   = 4'h9,
    NFC_OP_BYP_IN  = 4'hA,
    NFC_OP_BYP_PRG = 4'hB,
    NFC_OP_BYP_OUT = 4'hC,
    NFC_OP_AUTOSEL = 4'hD
  } nfc_op_t;
endpackage
